// [bac_exec.sv]
`default_nettype none

package bac_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OPC_BIT_AND = 8'h67;
	localparam logic [7:0] OPC_BIT_CMP = 8'h17;
	localparam int EXEC_CYCLES = 6;
	// Second instruction byte layout
	localparam int B2_ADDR_LSB = 4;
	localparam int B2_BIT_LSB = 1;
	localparam int B2_FORM = 0;
	// Flag positions in the flags byte
	localparam int FLG_C = 7;
	localparam int FLG_Z = 6;
	localparam int FLG_S = 5;
	localparam int FLG_V = 4;
	localparam int FLG_D = 3;
	localparam int FLG_H = 2;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_INSTR = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_WREG = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_FREG = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h14;
	localparam int CTRL_GO = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ILLEGAL = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic {PH_IDLE, PH_RUN} bac_phase_t;
	typedef enum logic [2:0] {SEL_CTRL, SEL_STAT, SEL_INSTR, SEL_WREG, SEL_FREG, SEL_FLAGS,
		SEL_NONE} bac_sel_t;
endpackage

module bac_exec
	import bac_pkg::*;
(
	input wire logic [7:0] opcode,
	input wire logic [7:0] ctl,
	input wire logic [7:0] wval,
	input wire logic [7:0] fval,
	input wire logic [7:0] flg_in,
	output logic [7:0] w_out,
	output logic [7:0] f_out,
	output logic [7:0] flg_out,
	output logic legal
);
	logic [2:0] b;
	logic res;

	// Overflow is undefined after both operations; it is simply left as it was
	always_comb
	begin
		b = ctl[B2_BIT_LSB +: 3];
		res = 1'b0;
		w_out = wval;
		f_out = fval;
		flg_out = flg_in;
		legal = 1'b0;
		case (opcode)
			OPC_BIT_AND:
			begin
				legal = 1'b1;
				if (!ctl[B2_FORM])
				begin
					res = wval[0] & fval[b];
					w_out[0] = res;
				end
				else
				begin
					res = fval[b] & wval[0];
					f_out[b] = res;
				end
				flg_out[FLG_Z] = ~res;
				flg_out[FLG_S] = 1'b0;
			end
			OPC_BIT_CMP:
			begin
				if (!ctl[B2_FORM])
				begin
					legal = 1'b1;
					flg_out[FLG_Z] = (wval[0] == fval[b]);
					flg_out[FLG_S] = 1'b0;
				end
			end
			default:
			begin
				legal = 1'b0;
			end
		endcase
	end
endmodule

`default_nettype wire

// [bac_top.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`default_nettype none

module bac_top
	import bac_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic BUSY
);
	localparam logic [2:0] LAST_CNT = 3'(EXEC_CYCLES - 1);

	typedef struct packed {
		bac_phase_t phase;
		logic [2:0] cnt;
		logic done;
		logic illegal;
		logic [23:0] instr;
		logic [7:0] wreg;
		logic [7:0] freg;
		logic [7:0] flags;
		logic aw_have;
		logic [ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic busy;
	} bac_state_t;

	bac_state_t s_reg;
	bac_state_t s_next;
	logic [7:0] w_res;
	logic [7:0] f_res;
	logic [7:0] flg_res;
	logic legal;
	logic go;
	logic clear_done;
	logic commit;

	function automatic bac_sel_t bac_decode(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CTRL: return SEL_CTRL;
			ADDR_STAT: return SEL_STAT;
			ADDR_INSTR: return SEL_INSTR;
			ADDR_WREG: return SEL_WREG;
			ADDR_FREG: return SEL_FREG;
			ADDR_FLAGS: return SEL_FLAGS;
			default: return SEL_NONE;
		endcase
	endfunction

	function automatic logic [31:0] bac_merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = d[8*i +: 8];
		return r;
	endfunction

	// Byte three (full register address) is held in instr[23:16]; the core is given only bytes one and two
	bac_exec u_exec (
		.opcode(s_reg.instr[7:0]),
		.ctl(s_reg.instr[15:8]),
		.wval(s_reg.wreg),
		.fval(s_reg.freg),
		.flg_in(s_reg.flags),
		.w_out(w_res),
		.f_out(f_res),
		.flg_out(flg_res),
		.legal(legal)
	);

	assign commit = (s_reg.phase == PH_RUN) && (s_reg.cnt == LAST_CNT);

	always_comb
	begin
		s_next = s_reg;
		go = 1'b0;
		clear_done = 1'b0;
		if (AWVALID && s_reg.awready)
		begin
			s_next.aw_have = 1'b1;
			s_next.aw_addr = AWADDR;
		end
		if (WVALID && s_reg.wready)
		begin
			s_next.w_have = 1'b1;
			s_next.w_data = WDATA;
			s_next.w_strb = WSTRB;
		end
		if (s_reg.bvalid && BREADY)
			s_next.bvalid = 1'b0;
		if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid)
		begin
			s_next.aw_have = 1'b0;
			s_next.w_have = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			// Operands are frozen while running so the result matches what was loaded
			if (s_reg.busy && bac_decode(s_reg.aw_addr) != SEL_STAT
				&& bac_decode(s_reg.aw_addr) != SEL_NONE)
				s_next.bresp = RESP_SLVERR;
			else
			begin
				case (bac_decode(s_reg.aw_addr))
					SEL_CTRL: go = s_reg.w_strb[0] & s_reg.w_data[CTRL_GO];
					SEL_STAT: clear_done = s_reg.w_strb[0] & s_reg.w_data[STAT_DONE];
					SEL_INSTR: s_next.instr = 24'(bac_merge({8'h00, s_reg.instr}, s_reg.w_data,
						s_reg.w_strb));
					SEL_WREG: s_next.wreg = 8'(bac_merge({24'h000000, s_reg.wreg}, s_reg.w_data,
						s_reg.w_strb));
					SEL_FREG: s_next.freg = 8'(bac_merge({24'h000000, s_reg.freg}, s_reg.w_data,
						s_reg.w_strb));
					SEL_FLAGS: s_next.flags = 8'(bac_merge({24'h000000, s_reg.flags}, s_reg.w_data,
						s_reg.w_strb));
					default: s_next.bresp = RESP_DECERR;
				endcase
			end
		end
		if (s_reg.rvalid && RREADY)
			s_next.rvalid = 1'b0;
		if (ARVALID && s_reg.arready)
		begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			s_next.rdata = 32'h00000000;
			case (bac_decode(ARADDR))
				SEL_CTRL: s_next.rdata = 32'h00000000;
				SEL_STAT: s_next.rdata = {29'h0, s_reg.illegal, s_reg.done, s_reg.busy};
				SEL_INSTR: s_next.rdata = {8'h00, s_reg.instr};
				SEL_WREG: s_next.rdata = {24'h000000, s_reg.wreg};
				SEL_FREG: s_next.rdata = {24'h000000, s_reg.freg};
				SEL_FLAGS: s_next.rdata = {24'h000000, s_reg.flags};
				default: s_next.rresp = RESP_DECERR;
			endcase
		end
		case (s_reg.phase)
			PH_IDLE:
			begin
				if (go)
				begin
					s_next.phase = PH_RUN;
					s_next.cnt = 3'h0;
				end
			end
			PH_RUN:
			begin
				s_next.cnt = s_reg.cnt + 3'h1;
				if (commit)
				begin
					s_next.phase = PH_IDLE;
					s_next.wreg = w_res;
					s_next.freg = f_res;
					s_next.flags = flg_res;
					s_next.illegal = ~legal;
				end
			end
			default: s_next.phase = PH_IDLE;
		endcase
		// Completion beats a clear arriving in the same cycle
		s_next.done = commit | (s_reg.done & ~clear_done);
		s_next.busy = (s_next.phase == PH_RUN);
		s_next.awready = ~s_next.aw_have & ~s_next.bvalid;
		s_next.wready = ~s_next.w_have & ~s_next.bvalid;
		s_next.arready = ~s_next.rvalid;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign AWREADY = s_reg.awready;
	assign WREADY = s_reg.wready;
	assign BVALID = s_reg.bvalid;
	assign BRESP = s_reg.bresp;
	assign ARREADY = s_reg.arready;
	assign RVALID = s_reg.rvalid;
	assign RDATA = s_reg.rdata;
	assign RRESP = s_reg.rresp;
	assign BUSY = s_reg.busy;

	logic is_and;
	logic is_cmp;
	logic form;
	logic [2:0] bpos;
	assign is_and = commit && s_reg.instr[7:0] == OPC_BIT_AND;
	assign is_cmp = commit && s_reg.instr[7:0] == OPC_BIT_CMP;
	assign form = s_reg.instr[8 + B2_FORM];
	assign bpos = s_reg.instr[8 + B2_BIT_LSB +: 3];

	property p_and_form0;
		@(posedge REF_CLK) disable iff (RST)
		is_and && !form |=> s_reg.wreg[0] == $past(s_reg.wreg[0] & s_reg.freg[bpos]);
	endproperty
	a_and_form0: assert property (p_and_form0)
		else $error("bit-AND form 0 result wrong");

	property p_and_keep0;
		@(posedge REF_CLK) disable iff (RST)
		is_and && !form |=> s_reg.wreg[7:1] == $past(s_reg.wreg[7:1])
			&& s_reg.freg == $past(s_reg.freg);
	endproperty
	a_and_keep0: assert property (p_and_keep0)
		else $error("bit-AND form 0 disturbed other bits");

	property p_and_form1;
		@(posedge REF_CLK) disable iff (RST)
		is_and && form |=> s_reg.freg[$past(bpos)] == $past(s_reg.freg[bpos] & s_reg.wreg[0])
			&& s_reg.wreg == $past(s_reg.wreg);
	endproperty
	a_and_form1: assert property (p_and_form1)
		else $error("bit-AND form 1 result or source wrong");

	property p_and_flags;
		@(posedge REF_CLK) disable iff (RST)
		is_and |=> s_reg.flags[FLG_Z] == (s_reg.wreg[0] == 1'b0 || form) && !form
			|| s_reg.flags[FLG_Z] == !s_reg.freg[$past(bpos)] && form;
	endproperty
	a_and_flags: assert property (p_and_flags)
		else $error("bit-AND zero flag wrong");

	property p_keep_cdh;
		@(posedge REF_CLK) disable iff (RST)
		commit |=> (!s_reg.flags[FLG_S] || s_reg.illegal)
			&& {s_reg.flags[FLG_C], s_reg.flags[FLG_D], s_reg.flags[FLG_H]}
			== $past({s_reg.flags[FLG_C], s_reg.flags[FLG_D], s_reg.flags[FLG_H]});
	endproperty
	a_keep_cdh: assert property (p_keep_cdh)
		else $error("sign flag not cleared or kept flags disturbed");

	property p_six_cycles;
		@(posedge REF_CLK) disable iff (RST)
		go && !s_reg.busy |=> s_reg.busy [*6] ##1 (!s_reg.busy && s_reg.done);
	endproperty
	a_six_cycles: assert property (p_six_cycles)
		else $error("execution did not take six cycles");

	property p_cmp_zero;
		@(posedge REF_CLK) disable iff (RST)
		is_cmp && !form |=> s_reg.flags[FLG_Z] == $past(s_reg.wreg[0] == s_reg.freg[bpos])
			&& !s_reg.flags[FLG_S];
	endproperty
	a_cmp_zero: assert property (p_cmp_zero)
		else $error("bit-compare zero flag wrong");

	property p_cmp_keep;
		@(posedge REF_CLK) disable iff (RST)
		is_cmp |=> s_reg.wreg == $past(s_reg.wreg) && s_reg.freg == $past(s_reg.freg)
			&& s_reg.illegal == $past(form);
	endproperty
	a_cmp_keep: assert property (p_cmp_keep)
		else $error("bit-compare changed an operand or misdecoded");
endmodule

`default_nettype wire

// [bit_and_compare_unit_tb.sv]
`default_nettype none
module bit_and_compare_unit_tb
	import bac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [7:0] opc, b2, w, f, fl, ew, ef, efl; logic ok;} bac_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = '0;
	logic [7:0] araddr = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, busy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	int err_total = 0;
	int tests_run = 0;
	int busy_cnt = 0;
	// Illegal rows last: their illegal status holds only until the next operation completes
	bac_row_t rows [11] = '{
		'{8'h67, 8'h12, 8'h07, 8'h05, 8'hFF, 8'h06, 8'h05, 8'hDF, 1'h1},
		'{8'h67, 8'h13, 8'h07, 8'h05, 8'h00, 8'h07, 8'h05, 8'h40, 1'h1},
		'{8'h67, 8'h1E, 8'h01, 8'h80, 8'h40, 8'h01, 8'h80, 8'h00, 1'h1},
		'{8'h67, 8'h1F, 8'h01, 8'h80, 8'h60, 8'h01, 8'h80, 8'h00, 1'h1},
		'{8'h67, 8'h17, 8'hFE, 8'hFF, 8'h9C, 8'hFE, 8'hF7, 8'hDC, 1'h1},
		'{8'h67, 8'h14, 8'hFF, 8'hFB, 8'h00, 8'hFE, 8'hFB, 8'h40, 1'h1},
		'{8'h17, 8'h12, 8'h07, 8'h01, 8'hFF, 8'h07, 8'h01, 8'h9F, 1'h1},
		'{8'h17, 8'h12, 8'h06, 8'h01, 8'h00, 8'h06, 8'h01, 8'h40, 1'h1},
		'{8'h17, 8'h10, 8'h03, 8'h01, 8'h20, 8'h03, 8'h01, 8'h40, 1'h1},
		'{8'h55, 8'h12, 8'h07, 8'h05, 8'hFF, 8'h07, 8'h05, 8'hFF, 1'h0},
		'{8'h17, 8'h13, 8'h07, 8'h01, 8'h00, 8'h07, 8'h01, 8'h00, 1'h0}};

	bac_top u_dut (.REF_CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .BUSY(busy));

	always #5 clk = ~clk;

	always @(posedge clk)
	begin
		if (busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
		input logic [3:0] st = 4'hF);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 100);
		// Ready stays high: lowering it here would clash with the next call's raise
		if (bvalid !== 1'b1)
			err_total++;
		check(bresp, er);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 100);
		if (rvalid !== 1'b1)
			err_total++;
		rd = rdata;
		check(rresp, er);
		check(rd, exp);
	endtask

	task automatic run_op(input bac_row_t r);
		wr(ADDR_WREG, {24'h0, r.w}, RESP_OKAY);
		wr(ADDR_FREG, {24'h0, r.f}, RESP_OKAY);
		wr(ADDR_FLAGS, {24'h0, r.fl}, RESP_OKAY);
		wr(ADDR_INSTR, {8'h00, 8'h01, r.b2, r.opc}, RESP_OKAY);
		wr(ADDR_STAT, 32'h2, RESP_OKAY);
		busy_cnt = 0;
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		// Six busy cycles plus margin for the done flag to land
		repeat (10) @(posedge clk);
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		wrap_up;
	end

	initial
	begin
		repeat (20) @(posedge clk);
		check(busy, 1'b0);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		for (int a = 0; a < 6; a++)
			rdc(8'(4 * a), 32'h0, RESP_OKAY);
		$display("reset values done");
		foreach (rows[i])
		begin
			run_op(rows[i]);
			rdc(ADDR_WREG, {24'h0, rows[i].ew}, RESP_OKAY);
			rdc(ADDR_FREG, {24'h0, rows[i].ef}, RESP_OKAY);
			rdc(ADDR_FLAGS, {24'h0, rows[i].efl}, RESP_OKAY);
			rdc(ADDR_STAT, rows[i].ok ? 32'h2 : 32'h6, RESP_OKAY);
			if (rows[i].ok)
			begin
				check(rd, 32'h2);
				check(busy_cnt, 6);
			end
			else
				check(rd[2], 1'b1);
			$display("row %0d done", i);
		end
		run_op(rows[0]);
		busy_cnt = 0;
		run_op(rows[0]);
		rdc(ADDR_WREG, {24'h0, rows[0].ew}, RESP_OKAY);
		$display("back-to-back done");
		rows[0].opc = OPC_BIT_AND;
		wr(ADDR_WREG, 32'h7, RESP_OKAY);
		wr(ADDR_FREG, 32'h5, RESP_OKAY);
		busy_cnt = 0;
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		wr(ADDR_WREG, 32'hAA, RESP_SLVERR);
		repeat (10) @(posedge clk);
		check(busy_cnt, 6);
		rdc(ADDR_WREG, 32'h6, RESP_OKAY);
		$display("write while busy done");
		wr(ADDR_INSTR, 32'hAABBCCDD, RESP_OKAY, 4'h2);
		rdc(ADDR_INSTR, 32'h0001CC67, RESP_OKAY);
		$display("byte lane write done");
		rdc(8'h18, 32'h0, RESP_DECERR);
		wr(8'h1C, 32'h1, RESP_DECERR);
		$display("unmapped access done");
		wrap_up;
	end
endmodule
`default_nettype wire
